/* File: dcfpf_cfg.svh */
`ifndef DCFPF_CFG_SVH
`define DCFPF_CFG_SVH

// offset select codes with serial select high
`define DCFPF_FS_PARALLEL   2'h0
`define DCFPF_FS_PRESET_A   2'h1
`define DCFPF_FS_PRESET_B   2'h2
`define DCFPF_FS_PRESET_C   2'h3

// preset offset values
`define DCFPF_PRESET_A      8
`define DCFPF_PRESET_B      16
`define DCFPF_PRESET_C      64

// flag reset value {empty_or_output_ready, full_or_input_ready, ae_n, af_n}
`define DCFPF_FLAGS_RST     4'h1
`define DCFPF_DATA_RST      36'h0

`endif

/* File: dcfpf_pkg.sv */
package dcfpf_pkg;

    // offset configuration sequence
    typedef enum logic [4:0] {
        CFG_LATCH  = 5'h01,
        CFG_PAR_X  = 5'h02,
        CFG_PAR_Y  = 5'h04,
        CFG_SERIAL = 5'h08,
        CFG_RUN    = 5'h10
    } dcfpf_cfg_st_t;

    // status flags as seen on the pins
    typedef struct packed {
        logic empty_or_output_ready;
        logic full_or_input_ready;
        logic ae_n;
        logic af_n;
    } dcfpf_flags_t;

endpackage : dcfpf_pkg

/* File: dcfpf_top.sv */
`timescale 1ns/1ps
`include "dcfpf_cfg.svh"

module dcfpf_top
    import dcfpf_pkg::*;
#(
    parameter int DATA_W = 36,
    parameter int DEPTH  = 1024
)(
    input  wire logic              I_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_CE,
    input  wire logic              I_A_SEL_N,
    input  wire logic              I_A_EN,
    input  wire logic              I_A_DIR,
    input  wire logic              I_A_MBOX,
    input  wire logic [DATA_W-1:0] I_A_DATA,
    input  wire logic              I_B_SEL_N,
    input  wire logic              I_B_EN,
    input  wire logic              I_FS_HI_SEN,
    input  wire logic              I_FS_LO_SD,
    input  wire logic              I_SERIAL_PROG_SEL,
    input  wire logic              I_TIMING_MODE_SEL,
    output logic      [DATA_W-1:0] O_A_DATA,
    output logic                   O_A_OE_N,
    output logic      [DATA_W-1:0] O_B_DATA,
    output logic                   O_B_OE_N,
    output logic                   O_EMPTY_OR_OUTPUT_READY,
    output logic                   O_FULL_OR_INPUT_READY,
    output logic                   O_ALMOST_EMPTY_FLAG_N,
    output logic                   O_ALMOST_FULL_FLAG_N
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    dcfpf_cfg_st_t    st_r;
    dcfpf_cfg_st_t    st_nxt;
    logic             fall_through_mode_r;
    logic [AW-1:0]    ofs_x_r;
    logic [AW-1:0]    ofs_y_r;
    logic [2*AW-1:0]  ofs_nxt;
    logic [CW-1:0]    bit_cnt_r;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [CW-1:0]    cnt_r;
    logic [CW-1:0]    cnt_nxt;
    logic             ov_r;
    logic             ov_nxt;
    logic [DATA_W-1:0] b_data_r;
    logic [DATA_W-1:0] mail_r;
    logic             a_oe_n_r;
    logic             b_oe_n_r;
    dcfpf_flags_t     flags_r;
    dcfpf_flags_t     flags_nxt;

    // port qualification
    wire a_acc    = I_CE & ~I_A_SEL_N & I_A_EN;
    wire b_acc    = I_CE & ~I_B_SEL_N & I_B_EN;
    wire a_wr     = a_acc & I_A_DIR;
    wire a_mb_wr  = a_wr & I_A_MBOX;
    wire a_fifo   = a_wr & ~I_A_MBOX;
    wire running  = (st_r == CFG_RUN);
    wire empty_w  = (cnt_r == '0);
    wire full_w   = (cnt_r == CW'(DEPTH));
    wire push     = a_fifo & running & ~full_w;
    wire pop_std  = b_acc & ~empty_w;
    wire pop_fall_through_mode = I_CE & ~empty_w & (~ov_r | b_acc);
    wire pop      = running & (fall_through_mode_r ? pop_fall_through_mode : pop_std);
    wire par_ld   = a_fifo & (st_r == CFG_PAR_X || st_r == CFG_PAR_Y);
    wire ser_sh   = I_CE & (st_r == CFG_SERIAL) & ~I_FS_HI_SEN;
    wire [1:0] fs_code = {I_FS_HI_SEN, I_FS_LO_SD};
    wire [CW-1:0] free_w = CW'(DEPTH) - cnt_nxt;

    // state and offsets after this edge, so flags are right from the first running cycle
    wire          run_nxt   = (st_nxt == CFG_RUN);
    wire [AW-1:0] ofs_x_nxt = ofs_nxt[AW-1:0];
    wire [AW-1:0] ofs_y_nxt = ofs_nxt[2*AW-1:AW];

    // next fill level and output-register valid
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (push && !pop)
            cnt_nxt = cnt_r + CW'(1);
        else if (pop && !push)
            cnt_nxt = cnt_r - CW'(1);
        ov_nxt = ov_r;
        if (pop)
            ov_nxt = 1'b1;
        else if (fall_through_mode_r && b_acc)
            ov_nxt = 1'b0;
    end

    // flag values, active-low empty/full, active-high ready
    always_comb
    begin
        flags_nxt = flags_r;
        if (run_nxt)
        begin
            flags_nxt.empty_or_output_ready = fall_through_mode_r ? ov_nxt : (cnt_nxt != '0);
            flags_nxt.full_or_input_ready = (cnt_nxt != CW'(DEPTH));
            flags_nxt.ae_n  = (cnt_nxt > {1'b0, ofs_x_nxt});
            flags_nxt.af_n  = (free_w > {1'b0, ofs_y_nxt});
        end
    end

    // offset configuration sequence
    always_comb
    begin
        st_nxt  = st_r;
        ofs_nxt = {ofs_y_r, ofs_x_r};
        unique case (st_r)
            CFG_LATCH:
            begin
                if (!I_SERIAL_PROG_SEL)
                    st_nxt = CFG_SERIAL;
                else
                begin
                    unique case (fs_code)
                        `DCFPF_FS_PARALLEL: st_nxt = CFG_PAR_X;
                        `DCFPF_FS_PRESET_A: ofs_nxt = {2{AW'(`DCFPF_PRESET_A)}};
                        `DCFPF_FS_PRESET_B: ofs_nxt = {2{AW'(`DCFPF_PRESET_B)}};
                        default:            ofs_nxt = {2{AW'(`DCFPF_PRESET_C)}};
                    endcase
                    if (fs_code != `DCFPF_FS_PARALLEL)
                        st_nxt = CFG_RUN;
                end
            end
            CFG_PAR_X:
            begin
                if (par_ld)
                begin
                    ofs_nxt = {ofs_y_r, I_A_DATA[AW-1:0]};
                    st_nxt  = CFG_PAR_Y;
                end
            end
            CFG_PAR_Y:
            begin
                if (par_ld)
                begin
                    ofs_nxt = {I_A_DATA[AW-1:0], ofs_x_r};
                    st_nxt  = CFG_RUN;
                end
            end
            CFG_SERIAL:
            begin
                if (ser_sh)
                begin
                    ofs_nxt = {ofs_y_r[AW-2:0], ofs_x_r, I_FS_LO_SD};
                    if (bit_cnt_r == CW'(2*AW-1))
                        st_nxt = CFG_RUN;
                end
            end
            CFG_RUN:
                st_nxt = CFG_RUN;
            default:
                st_nxt = CFG_LATCH;
        endcase
    end

    // configuration registers; mode pins caught on first enabled edge
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            st_r      <= CFG_LATCH;
            fall_through_mode_r    <= 1'b0;
            ofs_x_r   <= '0;
            ofs_y_r   <= '0;
            bit_cnt_r <= '0;
        end
        else if (I_CE)
        begin
            st_r               <= st_nxt;
            {ofs_y_r, ofs_x_r} <= ofs_nxt;
            if (st_r == CFG_LATCH)
                fall_through_mode_r <= ~I_TIMING_MODE_SEL;
            if (ser_sh)
                bit_cnt_r <= bit_cnt_r + CW'(1);
        end
    end

    // fifo storage
    always_ff @(posedge I_CLK)
    begin
        if (push)
            mem[wr_ptr_r] <= I_A_DATA;
    end

    // pointers, level, output register, flags
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
            ov_r     <= 1'b0;
            b_data_r <= `DCFPF_DATA_RST;
            flags_r  <= `DCFPF_FLAGS_RST;
        end
        else if (I_CE)
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + AW'(1);
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
                b_data_r <= mem[rd_ptr_r];
            end
            cnt_r   <= cnt_nxt;
            ov_r    <= ov_nxt;
            flags_r <= flags_nxt;
        end
    end

    // mailbox and pin enables
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            mail_r   <= `DCFPF_DATA_RST;
            a_oe_n_r <= 1'b1;
            b_oe_n_r <= 1'b1;
        end
        else if (I_CE)
        begin
            if (a_mb_wr)
                mail_r <= I_A_DATA;
            a_oe_n_r <= I_A_SEL_N | I_A_DIR;
            b_oe_n_r <= I_B_SEL_N;
        end
    end

    assign O_A_DATA                = mail_r;
    assign O_A_OE_N                = a_oe_n_r;
    assign O_B_DATA                = b_data_r;
    assign O_B_OE_N                = b_oe_n_r;
    assign O_EMPTY_OR_OUTPUT_READY = flags_r.empty_or_output_ready;
    assign O_FULL_OR_INPUT_READY   = flags_r.full_or_input_ready;
    assign O_ALMOST_EMPTY_FLAG_N   = flags_r.ae_n;
    assign O_ALMOST_FULL_FLAG_N    = flags_r.af_n;

    // checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    AST_B_HIZ: assert property (I_CE && I_B_SEL_N |=> O_B_OE_N)
        else $error("output port driven while deselected");
    AST_A_HIZ: assert property (I_CE && I_A_SEL_N |=> O_A_OE_N)
        else $error("input port driven while deselected");
    AST_EF_STD: assert property (running && !fall_through_mode_r |-> O_EMPTY_OR_OUTPUT_READY == (cnt_r != '0))
        else $error("empty flag disagrees with level");
    AST_OR_FALL_THROUGH_MODE: assert property (running && fall_through_mode_r |-> O_EMPTY_OR_OUTPUT_READY == ov_r)
        else $error("output ready disagrees with valid data");
    AST_FF: assert property (running |-> O_FULL_OR_INPUT_READY == !full_w)
        else $error("full flag disagrees with level");
    AST_NO_READ: assert property (I_CE && running && !fall_through_mode_r && !b_acc |=> $stable(O_B_DATA))
        else $error("output data changed without access");
    AST_SER: assert property (ser_sh |=> ofs_x_r[0] == $past(I_FS_LO_SD))
        else $error("serial bit not shifted in");
    AST_AE: assert property (running |-> O_ALMOST_EMPTY_FLAG_N == (cnt_r > {1'b0, ofs_x_r}))
        else $error("almost empty flag wrong");
    AST_MBOX: assert property (a_mb_wr |=> mail_r == $past(I_A_DATA) && $stable(wr_ptr_r))
        else $error("mailbox write went wrong");
    AST_PRESET: assert property (I_CE && st_r == CFG_LATCH && I_SERIAL_PROG_SEL && fs_code == `DCFPF_FS_PRESET_A
                                 |=> ofs_x_r == AW'(`DCFPF_PRESET_A) ##0 running)
        else $error("preset offset not loaded");

    // flag agreement on the full side
    AST_AF: assert property (running |-> O_ALMOST_FULL_FLAG_N == ((CW'(DEPTH) - cnt_r) > {1'b0, ofs_y_r}))
        else $error("almost full flag wrong");

    // level and data stability without access
    AST_A_IDLE: assert property (I_CE && (I_A_SEL_N || !I_A_EN) && !pop |=> $stable(cnt_r))
        else $error("level moved without input access");
    AST_B_IDLE: assert property (I_CE && running && !fall_through_mode_r && (I_B_SEL_N || !I_B_EN) && !push
                                 |=> $stable(cnt_r))
        else $error("level moved without output access");
    AST_FALL_THROUGH_MODE_HOLD: assert property (running && fall_through_mode_r && ov_r && !b_acc |=> $stable(O_B_DATA))
        else $error("fall-through data changed without read");
    AST_CE_FREEZE: assert property (!I_CE |=> $stable(cnt_r) && $stable(st_r) && $stable(O_B_DATA))
        else $error("state moved with clock enable low");

    // configuration loading
    AST_SER_END: assert property (ser_sh && bit_cnt_r == CW'(2*AW-1) |=> running)
        else $error("serial load did not end after last bit");
    AST_PAR_X: assert property (par_ld && st_r == CFG_PAR_X |=> ofs_x_r == $past(I_A_DATA[AW-1:0]))
        else $error("parallel offset not loaded");

    COV_FULL: cover property (running ##1 full_w);
    COV_FALL_THROUGH_MODE_READ: cover property (running && fall_through_mode_r && b_acc && ov_r);
    COV_SERIAL_DONE: cover property (st_r == CFG_SERIAL ##1 running);
    COV_PARALLEL: cover property (st_r == CFG_PAR_Y ##1 running);
    COV_CE_LOW: cover property (running && !I_CE ##1 I_CE);

endmodule : dcfpf_top

/* File: dcfpf_host_b.sv */
`timescale 1ns/1ps

// output-port reader host: select and enable for the output port
module dcfpf_host_b (
    input  wire logic i_sel,
    input  wire logic i_rd,
    input  wire logic i_gate,
    input  wire logic i_ready,
    output logic      o_sel_n,
    output logic      o_en
);
    // select active low, enable only on read requests
    assign o_sel_n = !i_sel;
    // fall-through reader gates its reads with output ready
    assign o_en    = i_rd && (!i_gate || i_ready);
endmodule : dcfpf_host_b

/* File: dcfpf_top_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end

module dcfpf_top_tb;
    import dcfpf_pkg::*;
    logic        clk = 0, rst_n = 0, a_sel_n = 1, a_en = 0, a_dir = 0, a_mbox = 0;
    logic        b_sel = 0, b_rd = 0, b_gate = 0, fs_hi = 1, fs_lo = 0, serial_programming_select = 1, mode = 1, ce = 1;
    logic [35:0] a_data = '0, a_q, b_q;
    logic        a_oe_n, b_oe_n, empty_or_output_ready, full_or_input_ready, ae_n, af_n, b_sel_n, b_en;
    int          err_count = 0, checked = 0;

    dcfpf_top #(.DATA_W(36), .DEPTH(16)) i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
        .I_A_SEL_N(a_sel_n), .I_A_EN(a_en), .I_A_DIR(a_dir), .I_A_MBOX(a_mbox), .I_A_DATA(a_data),
        .I_B_SEL_N(b_sel_n), .I_B_EN(b_en), .I_FS_HI_SEN(fs_hi), .I_FS_LO_SD(fs_lo),
        .I_SERIAL_PROG_SEL(serial_programming_select), .I_TIMING_MODE_SEL(mode), .O_A_DATA(a_q), .O_A_OE_N(a_oe_n),
        .O_B_DATA(b_q), .O_B_OE_N(b_oe_n), .O_EMPTY_OR_OUTPUT_READY(empty_or_output_ready),
        .O_FULL_OR_INPUT_READY(full_or_input_ready), .O_ALMOST_EMPTY_FLAG_N(ae_n), .O_ALMOST_FULL_FLAG_N(af_n));
    dcfpf_host_b i_host (.i_sel(b_sel), .i_rd(b_rd), .i_gate(b_gate), .i_ready(empty_or_output_ready),
        .o_sel_n(b_sel_n), .o_en(b_en));

    // 100 ns clock
    initial
    begin
        forever #50 clk = ~clk;
    end

    // one input-port edge with the given qualifiers
    task automatic a_op(input logic s, input logic e, input logic d, input logic m, input logic [35:0] v);
        @(negedge clk);
        a_sel_n = s; a_en = e; a_dir = d; a_mbox = m; a_data = v;
        @(posedge clk);
    endtask : a_op

    // idle both ports and let flags settle past boundary lag
    task automatic idle(input int n);
        @(negedge clk);
        a_sel_n = 1; a_en = 0; b_sel = 0; b_rd = 0;
        repeat (n) @(negedge clk);
    endtask : idle

    // one output-port read edge, data checked after it
    task automatic b_read(input logic s, input logic [35:0] exp);
        @(negedge clk);
        b_sel = s; b_rd = 1;
        @(negedge clk);
        b_rd = 0;
        `CHK("b_data", exp, b_q)
    endtask : b_read

    // master reset with configuration levels held
    task automatic do_reset(input logic p, input logic [1:0] fs, input logic md);
        @(negedge clk);
        rst_n = 0; serial_programming_select = p; {fs_hi, fs_lo} = fs; mode = md;
        repeat (10) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
    endtask : do_reset

    task automatic finish_test;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial
    begin
        repeat (10) @(negedge clk);
        `CHK("rst_flags", 4'h1, {empty_or_output_ready, full_or_input_ready, ae_n, af_n})
        `CHK("rst_oe", 2'h3, {a_oe_n, b_oe_n})
        rst_n = 1;
        @(negedge clk);
        // standard mode, preset offset 8
        do_reset(1, 2'h1, 1);
        idle(3);
        `CHK("std_idle", 4'h5, {empty_or_output_ready, full_or_input_ready, ae_n, af_n})
        a_op(1, 1, 1, 0, 36'hbad);
        a_op(0, 0, 1, 0, 36'hbad);
        idle(4);
        `CHK("no_write", 1'b0, empty_or_output_ready)
        for (int i = 0; i < 8; i++) a_op(0, 1, 1, 0, 36'h100 + i);
        idle(4);
        `CHK("ae_at_8", 2'h2, {empty_or_output_ready, ae_n})
        a_op(0, 1, 1, 0, 36'h108);
        idle(4);
        `CHK("ae_at_9", 1'b1, ae_n)
        for (int i = 9; i < 17; i++) a_op(0, 1, 1, 0, 36'h100 + i);
        idle(4);
        `CHK("full", 2'h0, {full_or_input_ready, af_n})
        b_read(0, '0);
        `CHK("b_oe_off", 1'b1, b_oe_n)
        for (int i = 0; i < 16; i++) b_read(1, 36'h100 + i);
        `CHK("b_oe_on", 1'b0, b_oe_n)
        idle(4);
        `CHK("drained", 3'h2, {empty_or_output_ready, full_or_input_ready, ae_n})
        `CHK("b_oe_rel", 1'b1, b_oe_n)
        // clock enable low: a qualified write must not land
        ce = 0;
        a_op(0, 1, 1, 0, 36'hbad);
        idle(2);
        `CHK("ce_frozen", 1'b0, empty_or_output_ready)
        ce = 1;
        a_op(0, 1, 1, 1, 36'h5a5a5a5a5);
        a_op(0, 1, 0, 0, '0);
        idle(0);
        `CHK("mbox", 36'h5a5a5a5a5, a_q)
        `CHK("a_oe_on", 1'b0, a_oe_n)
        idle(4);
        `CHK("a_oe_off", 1'b1, a_oe_n)
        `CHK("mbox_no_fifo", 1'b0, empty_or_output_ready)
        // standard mode, parallel offsets x=1 y=2
        do_reset(1, 2'h0, 1);
        a_op(0, 1, 1, 0, 36'h1);
        a_op(0, 1, 1, 0, 36'h2);
        a_op(0, 1, 1, 0, 36'h300);
        idle(4);
        `CHK("par_x1", 2'h2, {empty_or_output_ready, ae_n})
        a_op(0, 1, 1, 0, 36'h301);
        idle(4);
        `CHK("par_x2", 2'h3, {ae_n, af_n})
        b_read(1, 36'h300);
        // fall-through mode, serial offsets y=2 x=3
        do_reset(0, 2'h3, 0);
        for (int i = 7; i >= 0; i--)
        begin
            @(negedge clk);
            fs_hi = 0; fs_lo = 1'(8'h23 >> i);
        end
        @(negedge clk);
        fs_hi = 1;
        idle(3);
        `CHK("ft_idle", 3'h2, {empty_or_output_ready, full_or_input_ready, ae_n})
        for (int i = 0; i < 4; i++) a_op(0, 1, 1, 0, 36'h200 + i);
        idle(4);
        `CHK("ft_first", 36'h200, b_q)
        `CHK("ft_x3", 2'h2, {empty_or_output_ready, ae_n})
        for (int i = 4; i < 17; i++) a_op(0, 1, 1, 0, 36'h200 + i);
        idle(4);
        `CHK("ft_full", 3'h2, {full_or_input_ready, ae_n, af_n})
        b_gate = 1;
        b_read(1, 36'h201);
        idle(4);
        `CHK("ft_space", 1'b1, full_or_input_ready)
        finish_test();
    end
endmodule : dcfpf_top_tb
